/* hw/i2c_ctl_pkg.sv */
package i2c_ctl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_PRIMARY   = 8'h04;
	localparam logic [7:0] OFS_SECONDARY = 8'h08;
	localparam logic [7:0] OFS_OWN_ADDR  = 8'h10;
	localparam logic [7:0] OFS_DATA      = 8'h18;
	// control field positions
	localparam int CR_PE    = 5;
	localparam int CR_GC    = 4;
	localparam int CR_START = 3;
	localparam int CR_ACK   = 2;
	localparam int CR_STOP  = 1;
	localparam int CR_ITE   = 0;
	// reset values
	localparam logic [7:0] CONTROL_RST  = 8'h00;
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] DATA_RST     = 8'h00;
	// special addresses and the 10-bit header pattern
	localparam logic [7:0] GC_ADDR      = 8'h00;
	localparam logic [7:0] IGNORED_ADDR = 8'h01;
	localparam logic [4:0] HDR_PATTERN  = 5'h1e;
	// bus timing: half of the serial clock period
	localparam int CLK_FREQ_KHZ = 20000;
	localparam int SCL_HALF_NS  = 5000;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_FREQ_KHZ) / 1000000;
	// master sequencer states
	typedef enum logic [3:0] {
		m_idle  = 4'h1,
		m_start = 4'h2,
		m_run   = 4'h4,
		m_stop  = 4'h8
	} mstate_t;
endpackage : i2c_ctl_pkg

/* hw/i2c_ctl.sv */
`timescale 1ns/10ps
module i2c_ctl #(
	parameter int HALF_CYC = i2c_ctl_pkg::SCL_HALF_CYC
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	output logic            irq_bus,
	output logic            irq_data
);
	logic       rst_meta, rst_n;          // reset release chain
	logic       scl_m, scl_s, scl_q;      // clock line sync and history
	logic       sda_m, sda_s, sda_q;      // data line sync and history
	logic       pe, gc_en, start_req;     // control bits
	logic       ack_en, stop_req, irq_enable;
	logic [7:0] own_addr;                 // own slave address
	logic [7:0] data_reg;                 // last written or received byte
	logic [15:0] div_cnt;                 // half period divider
	i2c_ctl_pkg::mstate_t mstate;         // master sequencer
	logic [1:0] mph;                      // phase inside start/stop
	logic       mscl_low, msda_low;       // master line pulls
	logic [7:0] shift;                    // byte shifter
	logic [3:0] bitcnt;                   // rising edges seen in byte
	logic       byte_run, tx_role;        // byte in progress, we send
	logic       addr_phase, sess;         // slave address / addressed
	logic       m_addr, m_second;         // master address bytes
	logic       slave_txwait;             // slave waits for first byte
	logic       drive_sda, pull_scl;      // engine line pulls
	logic       busy, byte_finished_flag, own_address_matched, sb, msl; // primary status
	logic       header, dir;
	logic       end_of_address_flag, af, stop_detected_flag;         // secondary status
	logic       arbitration_lost_flag, bus_error_flag, gcal;
	logic       sr1_seen, sr2_seen;       // first half of clear pairs
	logic       suppress;                 // hide stop after release

	// reset: asynchronous assert, two-stage release
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// line synchronisers
	// only the second stage and its history feed detectors
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m, scl_s, scl_q} <= 3'h7;
			{sda_m, sda_s, sda_q} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
		end
	end

	// bus condition detection on synchronised lines
	wire scl_rise  = scl_s & ~scl_q;
	wire scl_fall  = ~scl_s & scl_q;
	wire start_det = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// register decode
	wire cr_wr  = wr & (addr == i2c_ctl_pkg::OFS_CONTROL);
	wire oa_wr  = wr & (addr == i2c_ctl_pkg::OFS_OWN_ADDR);
	wire dr_wr  = wr & (addr == i2c_ctl_pkg::OFS_DATA);
	wire sr1_rd = rd & (addr == i2c_ctl_pkg::OFS_PRIMARY);
	wire sr2_rd = rd & (addr == i2c_ctl_pkg::OFS_SECONDARY);
	wire dr_rd  = rd & (addr == i2c_ctl_pkg::OFS_DATA);

	// derived state and events
	wire tick     = (div_cnt == 16'(HALF_CYC - 1));
	wire in_run   = (mstate == i2c_ctl_pkg::m_run);
	wire in_idle  = (mstate == i2c_ctl_pkg::m_idle);
	wire got_ack  = ~sda_s;
	wire byte_done = scl_rise & byte_run & (bitcnt == 4'h8);
	wire matched  = ((shift[7:1] == own_addr[7:1])
			& (shift != i2c_ctl_pkg::IGNORED_ADDR))
			| (gc_en & (shift == i2c_ctl_pkg::GC_ADDR));
	wire addr_ok  = matched & ack_en;
	wire hdr_cond = (data_reg[7:3] == i2c_ctl_pkg::HDR_PATTERN)
			& ~data_reg[0] & ~m_second;
	wire m_tx_done = byte_done & tx_role & msl;
	wire hdr_ev   = m_tx_done & m_addr & got_ack & hdr_cond;
	wire end_of_address_flag_ev = m_tx_done & m_addr & got_ack & ~hdr_cond;
	wire af_ev    = byte_done & tx_role & ~got_ack & (msl | sess);
	wire btf_tx_ev = (m_tx_done & ~m_addr & got_ack)
			| (byte_done & tx_role & sess & ~msl);
	wire btf_rx_ev = byte_done & ~tx_role & ~addr_phase & (msl | sess);
	wire own_address_matched_ev  = byte_done & addr_phase & addr_ok;
	wire arbitration_lost_flag_ev  = scl_rise & byte_run & tx_role & msl
			& (bitcnt < 4'h8) & ~drive_sda & ~sda_s;
	// a start or stop just after the first rise sits in the slot of a
	// new byte, so only later positions count as misplaced
	wire bus_error_flag_ev  = pe & (start_det | stop_det) & byte_run
			& (bitcnt > 4'h1);
	wire stop_detected_flag_ev = pe & stop_det & sess & ~suppress;
	wire stop_release = stop_req & ~msl & sess & byte_finished_flag;
	wire load     = dr_wr & pe & ~byte_run
			& ((msl & in_run) | (sess & tx_role));
	wire hold_flags = header | sb | byte_finished_flag | own_address_matched | end_of_address_flag | slave_txwait;
	wire line_err = af | arbitration_lost_flag | bus_error_flag | stop_detected_flag; // error flags free the clock
	wire hold_scl = pe & hold_flags & ~line_err;
	wire go_start = start_req & pe
			& ((in_idle & ~busy) | (in_run & ~byte_run & mscl_low));
	wire go_stop  = stop_req & msl & in_run
			& (~byte_run | (mscl_low & hold_flags));
	wire start_sent = (mstate == i2c_ctl_pkg::m_start) & tick
			& (mph == 2'h3);
	wire stop_sent = (mstate == i2c_ctl_pkg::m_stop) & tick
			& (mph == 2'h3);
	wire event_flag = byte_finished_flag | own_address_matched | sb | af | stop_detected_flag | arbitration_lost_flag | bus_error_flag | header | end_of_address_flag;
	wire ack_drive = ack_en & (addr_phase ? matched : 1'b1);
	wire fall_drive = (byte_run & tx_role & (bitcnt < 4'h8)) ? ~shift[7]
			: (byte_run & ~tx_role & (bitcnt == 4'h8)) ? ack_drive
			: 1'b0;
	wire btf_clr = (tx_role ? dr_wr : (dr_rd & sr1_seen)) | stop_release;

	// read data multiplexer, reserved bits read zero
	wire [7:0] rd_mux =
		(addr == i2c_ctl_pkg::OFS_CONTROL) ?
			{2'h0, pe, gc_en, start_req, ack_en, stop_req, irq_enable} :
		(addr == i2c_ctl_pkg::OFS_PRIMARY) ?
			{event_flag, header, dir, busy, byte_finished_flag, own_address_matched, msl, sb} :
		(addr == i2c_ctl_pkg::OFS_SECONDARY) ?
			{2'h0, end_of_address_flag, af, stop_detected_flag, arbitration_lost_flag, bus_error_flag, gcal} :
		(addr == i2c_ctl_pkg::OFS_OWN_ADDR) ? own_addr :
		(addr == i2c_ctl_pkg::OFS_DATA) ? data_reg : 8'h00;

	// open drain: the level driven is always low
	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = mscl_low | pull_scl;
	assign sda_oe = msda_low | drive_sda;

	// read data stands one cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rdata <= 8'h00;
		else
			rdata <= rd ? rd_mux : 8'h00;
	end

	// control register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{pe, gc_en, start_req} <= i2c_ctl_pkg::CONTROL_RST[5:3];
			{ack_en, stop_req, irq_enable} <= i2c_ctl_pkg::CONTROL_RST[2:0];
		end else if (cr_wr && !pe) begin
			pe <= wdata[i2c_ctl_pkg::CR_PE];
		end else if (cr_wr) begin
			pe        <= wdata[i2c_ctl_pkg::CR_PE];
			gc_en     <= wdata[i2c_ctl_pkg::CR_GC];
			start_req <= wdata[i2c_ctl_pkg::CR_START];
			ack_en    <= wdata[i2c_ctl_pkg::CR_ACK];
			stop_req  <= wdata[i2c_ctl_pkg::CR_STOP];
			irq_enable       <= wdata[i2c_ctl_pkg::CR_ITE];
		end else if (!pe) begin
			{gc_en, start_req, ack_en, irq_enable} <= 4'h0;
		end else begin
			if (start_sent)
				start_req <= 1'b0;
			if (stop_sent)
				stop_req <= 1'b0;
		end
	end

	// own address and data registers, kept over disable
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			own_addr <= i2c_ctl_pkg::OWN_ADDR_RST;
			data_reg <= i2c_ctl_pkg::DATA_RST;
		end else begin
			if (oa_wr)
				own_addr <= wdata;
			if (dr_wr)
				data_reg <= wdata;
			else if (btf_rx_ev | own_address_matched_ev)
				data_reg <= shift;
		end
	end

	// free running half period divider
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			div_cnt <= 16'h0000;
		else
			div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
	end

	// master sequencer: start, byte clocking, stop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mstate   <= i2c_ctl_pkg::m_idle;
			mph      <= 2'h0;
			mscl_low <= 1'b0;
			msda_low <= 1'b0;
		end else if (!pe || arbitration_lost_flag_ev) begin
			mstate   <= i2c_ctl_pkg::m_idle;
			mph      <= 2'h0;
			mscl_low <= 1'b0;
			msda_low <= 1'b0;
		end else begin
			case (mstate)
			i2c_ctl_pkg::m_idle: begin
				if (go_start) begin
					mstate <= i2c_ctl_pkg::m_start;
					mph    <= 2'h0;
				end
			end
			i2c_ctl_pkg::m_start: begin
				// release data, release clock, pull data, pull clock
				if (tick) begin
					mph <= mph + 2'h1;
					case (mph)
					2'h0: msda_low <= 1'b0;
					2'h1: mscl_low <= 1'b0;
					2'h2: msda_low <= 1'b1;
					default: begin
						mscl_low <= 1'b1;
						mstate   <= i2c_ctl_pkg::m_run;
					end
					endcase
				end
			end
			i2c_ctl_pkg::m_run: begin
				if (go_stop) begin
					mstate <= i2c_ctl_pkg::m_stop;
					mph    <= 2'h0;
				end else if (go_start) begin
					mstate <= i2c_ctl_pkg::m_start;
					mph    <= 2'h0;
				end else if (tick) begin
					// data handed back a half period after start
					if (msda_low)
						msda_low <= 1'b0;
					else if (mscl_low && (byte_run || line_err)
							&& !hold_scl)
						mscl_low <= 1'b0;
					// clock left free between bytes while an error flag stands
					else if (!mscl_low && scl_s
							&& (byte_run || !line_err))
						mscl_low <= 1'b1;
				end
			end
			i2c_ctl_pkg::m_stop: begin
				// pull clock, pull data, release clock, release data;
				// the clock may stand released after a failed byte
				if (tick) begin
					mph <= mph + 2'h1;
					case (mph)
					2'h0: mscl_low <= 1'b1;
					2'h1: msda_low <= 1'b1;
					2'h2: mscl_low <= 1'b0;
					default: begin
						msda_low <= 1'b0;
						mstate   <= i2c_ctl_pkg::m_idle;
					end
					endcase
				end
			end
			default: mstate <= i2c_ctl_pkg::m_idle;
			endcase
		end
	end

	// byte engine shared by master and slave
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{shift, bitcnt} <= 12'h000;
			{byte_run, tx_role, addr_phase, sess} <= 4'h0;
			{m_addr, m_second, slave_txwait, drive_sda} <= 4'h0;
		// disable drops the engine and releases the data line
		end else if (!pe) begin
			{shift, bitcnt} <= 12'h000;
			{byte_run, tx_role, addr_phase, sess} <= 4'h0;
			{m_addr, m_second, slave_txwait, drive_sda} <= 4'h0;
		end else if (bus_error_flag_ev || arbitration_lost_flag_ev || stop_release || stop_det) begin
			{byte_run, sess, addr_phase} <= 3'h0;
			{slave_txwait, drive_sda} <= 2'h0;
		end else if (start_det && in_idle) begin
			// foreign start: listen for a slave address
			{sess, tx_role, byte_run, addr_phase} <= 4'h3;
			bitcnt <= 4'h0;
		end else if (load) begin
			shift    <= wdata;
			bitcnt   <= 4'h0;
			byte_run <= 1'b1;
			tx_role  <= 1'b1;
			m_addr   <= sb | header;
			m_second <= header;
			slave_txwait <= 1'b0;
			// first bit only while the clock is low
			if (!scl_s)
				drive_sda <= ~wdata[7];
		end else if (byte_done) begin
			bitcnt <= 4'h0;
			m_addr <= 1'b0;
			if (addr_phase) begin
				addr_phase   <= 1'b0;
				sess         <= addr_ok;
				tx_role      <= shift[0];
				byte_run     <= addr_ok & ~shift[0];
				slave_txwait <= addr_ok & shift[0];
			end else if (tx_role) begin
				// master reading: switch to receive after address
				byte_run <= m_addr & got_ack & data_reg[0] & ~hdr_cond;
				tx_role  <= ~(m_addr & got_ack & data_reg[0] & ~hdr_cond);
			end else begin
				byte_run <= 1'b1;
			end
		end else if (scl_rise && byte_run) begin
			shift  <= {shift[6:0], sda_s};
			bitcnt <= bitcnt + 4'h1;
		end else if (scl_fall) begin
			drive_sda <= fall_drive;
		end
	end

	// slave stretches the clock once it is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			pull_scl <= 1'b0;
		else
			pull_scl <= hold_scl & sess & ~msl & (pull_scl | ~scl_s);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			busy <= 1'b0;
		else
			busy <= start_det | (busy & ~stop_det);
	end

	// status flags; a set always wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{byte_finished_flag, own_address_matched, sb, msl, header, dir} <= 6'h00;
			{end_of_address_flag, af, stop_detected_flag, arbitration_lost_flag, bus_error_flag, gcal} <= 6'h00;
			{sr1_seen, sr2_seen, suppress} <= 3'h0;
		end else if (!pe) begin
			{byte_finished_flag, own_address_matched, sb, msl, header, dir} <= 6'h00;
			{end_of_address_flag, af, stop_detected_flag, arbitration_lost_flag, bus_error_flag, gcal} <= 6'h00;
			{sr1_seen, sr2_seen, suppress} <= 3'h0;
		end else begin
			sr1_seen <= sr1_rd | (sr1_seen & ~(dr_wr | dr_rd));
			sr2_seen <= sr2_rd | (sr2_seen & ~cr_wr);
			// start sent, cleared by read then write
			sb <= start_sent | (sb & ~(dr_wr & sr1_seen));
			header <= hdr_ev | (header & ~(dr_wr & (sr1_seen | sr2_seen)));
			end_of_address_flag <= end_of_address_flag_ev | (end_of_address_flag & ~(cr_wr & sr2_seen));
			own_address_matched <= own_address_matched_ev | (own_address_matched & ~sr1_rd);
			byte_finished_flag <= btf_tx_ev | btf_rx_ev | (byte_finished_flag & ~btf_clr);
			dir <= btf_tx_ev
				| (dir & ~(btf_clr | stop_det | arbitration_lost_flag_ev | btf_rx_ev));
			// nack failure cleared by secondary read
			af <= af_ev | (af & ~sr2_rd);
			// stop event cleared by secondary read
			stop_detected_flag <= stop_detected_flag_ev | (stop_detected_flag & ~sr2_rd);
			// error flags end stretching, lines left to software
			arbitration_lost_flag <= arbitration_lost_flag_ev | (arbitration_lost_flag & ~sr2_rd);
			bus_error_flag <= bus_error_flag_ev | (bus_error_flag & ~sr2_rd);
			gcal <= (own_address_matched_ev & gc_en & (shift == i2c_ctl_pkg::GC_ADDR))
				| (gcal & ~stop_det);
			msl <= (go_start & in_idle) | (msl & ~(stop_det | arbitration_lost_flag_ev));
			// released lines hide the next stop event
			suppress <= stop_release | (suppress & ~stop_det);
		end
	end

	// two request lines, flags stay pollable
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_bus  <= 1'b0;
			irq_data <= 1'b0;
		end else begin
			irq_bus  <= irq_enable & (sb | own_address_matched | af | stop_detected_flag | arbitration_lost_flag | bus_error_flag
				| header | end_of_address_flag);
			irq_data <= irq_enable & byte_finished_flag;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_start_go;
		go_start && in_idle;
	endsequence
	sequence s_start_done;
		##[1:1000] (sb && !start_req);
	endsequence

	a_disable_clear: assert property (!pe |=> !(byte_finished_flag|own_address_matched|sb|msl|header))
		else $error("status not cleared while disabled");
	a_first_write: assert property (cr_wr && !pe |=> !start_req && !ack_en)
		else $error("first enable write set other bits");
	a_gc_ack: assert property (scl_fall && byte_run && addr_phase
		&& gc_en && ack_en && bitcnt == 4'h8 && shift == 8'h00
		&& !(bus_error_flag_ev || stop_det || start_det) |=> drive_sda)
		else $error("general call not acknowledged");
	a_start_seq: assert property (s_start_go |-> s_start_done)
		else $error("start not sent in time");
	a_no_ack: assert property (scl_fall && byte_run && !tx_role
		&& bitcnt == 4'h8 && !ack_en && !load |=> !drive_sda)
		else $error("acknowledge driven while disabled");
	a_stop_clear: assert property (stop_sent && !cr_wr |=> !stop_req)
		else $error("stop request not cleared");
	a_irq_data: assert property (irq_enable && byte_finished_flag |=> irq_data)
		else $error("data interrupt missing");
	a_slave_hold: assert property (hold_scl && sess && !msl
		&& !scl_s ##1 hold_scl |-> scl_oe)
		else $error("clock not stretched");
	a_dir_tx: assert property (btf_tx_ev |=> dir && byte_finished_flag)
		else $error("direction not set after transmit");
	a_busy_start: assert property (start_det |=> busy)
		else $error("busy not set on start");
	// back to slave on arbitration loss
	a_arbitration_lost_flag_slave: assert property (arbitration_lost_flag_ev |=> !msl && arbitration_lost_flag && !mscl_low)
		else $error("arbitration loss kept master mode");
endmodule : i2c_ctl

/* tb/far_slave.sv */
`timescale 1ns/10ps
// behavioural slave on the far side: takes every byte, acks unless told not
module far_slave (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nack,
	output logic            sda_low,
	output logic      [7:0] last_byte
);
	int         cnt;    // clock rises seen in the current byte
	logic       active; // a frame is open on the bus
	logic [7:0] shift;  // incoming bits, msb first

	initial begin
		sda_low = 1'b0;
		active = 1'b0;
		cnt = 0;
		shift = 8'h00;
		last_byte = 8'h00;
	end
	// start or repeated start opens a frame
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			active = 1'b1;
			cnt = 0;
		end
	end
	// stop closes it, so a later clock is not miscounted
	always @(posedge sda) begin
		if (scl === 1'b1) active = 1'b0;
	end
	// data bits are taken while the clock is high
	always @(posedge scl) begin
		if (active) begin
			cnt = cnt + 1;
			if (cnt <= 8) shift = {shift[6:0], sda};
			if (cnt == 8) last_byte = shift;
		end
	end
	// ack held across the ninth clock, line released right after it
	always @(negedge scl) begin
		if (active && cnt == 8) begin
			sda_low <= ~nack;
		end else if (active && cnt == 9) begin
			sda_low <= 1'b0;
			cnt = 0;
		end
	end
endmodule : far_slave

/* tb/i2c_ctl_bench.sv */
`timescale 1ns/10ps
// bench: register tasks, a foreign master on the wires, a far slave
module i2c_ctl_bench;
	localparam logic [7:0] CTL = i2c_ctl_pkg::OFS_CONTROL;
	localparam logic [7:0] SR1 = i2c_ctl_pkg::OFS_PRIMARY;
	localparam logic [7:0] SR2 = i2c_ctl_pkg::OFS_SECONDARY;
	localparam logic [7:0] DAT = i2c_ctl_pkg::OFS_DATA;
	// slave cases: bus address, control value, ack expected
	localparam logic [7:0] S_ADR [5] = '{8'h42, 8'h00, 8'h01, 8'h00, 8'h42};
	localparam logic [7:0] S_CTL [5] = '{8'h34, 8'h34, 8'h34, 8'h24, 8'h30};
	localparam logic [7:0] S_ACK [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	logic       clock, nrst, wr, rd;   // clock, reset, strobes
	logic [7:0] addr, wdata, rdata;    // register port
	logic       scl_o, scl_oe, sda_o, sda_oe;
	logic       irq_bus, irq_data;
	logic       tb_scl_low, tb_sda_low; // foreign master pulls
	logic       p_sda_low, nack;        // far slave pull and nack order
	logic [7:0] p_byte;                 // last byte the far slave took
	// open-drain wires with pull-ups
	wire        scl = (scl_oe ? scl_o : 1'b1) & ~tb_scl_low;
	wire        sda = (sda_oe ? sda_o : 1'b1) & ~tb_sda_low & ~p_sda_low;
	int         failures, n_compared;

	i2c_ctl #(.HALF_CYC(4)) u_i2c_ctl (.clock(clock), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .irq_bus(irq_bus),
		.irq_data(irq_data));
	far_slave u_far_slave (.scl(scl), .sda(sda), .nack(nack),
		.sda_low(p_sda_low), .last_byte(p_byte));

	// 50 ns clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	task timeout;
		failures++;
		$display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
		stop_test();
	endtask : timeout
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask : chk_reg
	// polling reads count as status reads, which the clears rely on
	task poll(input logic [7:0] a, input int b, input logic v);
		logic [7:0] d;
		for (int k = 0; k < 3000; k++) begin
			rd_reg(a, d);
			if (d[b] === v) return;
		end
		timeout();
	endtask : poll
	task half;
		repeat (4) @(posedge clock);
	endtask : half
	// a stretched clock line is waited out, but not for ever
	task wait_scl;
		for (int k = 0; k < 400; k++) begin
			if (scl === 1'b1) return;
			@(posedge clock);
		end
		timeout();
	endtask : wait_scl
	task fm_bit(input logic b, output logic s);
		tb_sda_low <= ~b;
		half();
		tb_scl_low <= 1'b0;
		wait_scl();
		half();
		s = sda;
		tb_scl_low <= 1'b1;
	endtask : fm_bit
	task fm_start;
		@(posedge clock);
		tb_sda_low <= 1'b1;
		half();
		tb_scl_low <= 1'b1;
		half();
	endtask : fm_start
	task fm_stop;
		@(posedge clock);
		tb_sda_low <= 1'b1;
		half();
		tb_scl_low <= 1'b0;
		wait_scl();
		half();
		tb_sda_low <= 1'b0;
		half();
	endtask : fm_stop
	task fm_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) fm_bit(v[i], s);
		fm_bit(1'b1, s);
		ack = ~s;
	endtask : fm_byte

	task t_reset;
		chk_reg(CTL, 8'h00);
		chk_reg(SR1, 8'h00);
		chk_reg(8'h2c, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task t_enable;
		wr_reg(CTL, 8'h25);
		chk_reg(CTL, 8'h20);
		wr_reg(CTL, 8'h25);
		chk_reg(CTL, 8'h25);
		$display("test enable done");
	endtask : t_enable
	// foreign master addresses us: own, general call, ignored, ack off
	task t_slave;
		logic a;
		wr_reg(i2c_ctl_pkg::OFS_OWN_ADDR, 8'h42);
		for (int i = 0; i < 5; i++) begin
			wr_reg(CTL, S_CTL[i]);
			fm_start();
			fm_byte(S_ADR[i], a);
			chk({7'h00, a}, S_ACK[i]);
			if (S_ACK[i][0]) begin
				half();
				chk({7'h00, scl_oe}, 8'h01);
				chk_reg(SR1, 8'h94);
				chk_reg(SR2, {7'h00, S_ADR[i] == 8'h00});
			end
			fm_stop();
			chk_reg(SR2, {4'h0, S_ACK[i][0], 3'h0});
			chk_reg(SR2, 8'h00);
			chk_reg(SR1, 8'h00);
		end
		wr_reg(CTL, 8'h25);
		$display("test slave done");
	endtask : t_slave
	// foreign master reads from us, answers with a nack, we release
	task t_slave_tx;
		logic [7:0] d;
		logic       a;
		wr_reg(CTL, 8'h34);
		fm_start();
		fm_byte(8'h43, a);
		chk({7'h00, a}, 8'h01);
		chk_reg(SR1, 8'h94);
		wr_reg(DAT, 8'hc3);
		for (int i = 7; i >= 0; i--) fm_bit(1'b1, d[i]);
		fm_bit(1'b1, a);
		chk(d, 8'hc3);
		chk_reg(SR1, 8'hb8);
		wr_reg(CTL, 8'h36);
		chk_reg(SR1, 8'h90);
		wr_reg(CTL, 8'h34);
		fm_stop();
		chk_reg(SR2, 8'h10);
		chk_reg(SR1, 8'h00);
		$display("test slave transmit done");
	endtask : t_slave_tx
	task t_master;
		logic [7:0] d;
		nack <= 1'b0;
		wr_reg(CTL, 8'h2d);
		poll(SR1, 0, 1'b1);
		chk_reg(SR1, 8'h93);
		chk_reg(CTL, 8'h25);
		chk({6'h00, irq_bus, scl_oe}, 8'h03);
		wr_reg(DAT, 8'ha4);
		poll(SR2, 5, 1'b1);
		chk(p_byte, 8'ha4);
		wr_reg(CTL, 8'h25);
		chk_reg(SR2, 8'h00);
		chk_reg(SR1, 8'h12);
		wr_reg(DAT, 8'h5a);
		poll(SR1, 3, 1'b1);
		chk_reg(SR1, 8'hba);
		chk({7'h00, irq_data}, 8'h01);
		chk(p_byte, 8'h5a);
		wr_reg(CTL, 8'h27);
		poll(SR1, 4, 1'b0);
		chk_reg(CTL, 8'h25);
		rd_reg(SR1, d);
		chk(d & 8'h02, 8'h00);
		$display("test master done");
	endtask : t_master
	// address not acknowledged: failure flagged, clock not held
	task t_nack;
		int k;
		nack <= 1'b1;
		wr_reg(CTL, 8'h2d);
		poll(SR1, 0, 1'b1);
		wr_reg(DAT, 8'h4e);
		repeat (2) @(posedge clock);
		for (k = 0; k < 3000 && irq_bus !== 1'b1; k++) @(posedge clock);
		if (k == 3000) timeout();
		half();
		chk({7'h00, scl_oe}, 8'h00);
		chk_reg(SR2, 8'h10);
		wr_reg(CTL, 8'h27);
		poll(SR1, 4, 1'b0);
		$display("test nack done");
	endtask : t_nack
	task t_disable;
		wr_reg(CTL, 8'h37);
		wr_reg(CTL, 8'h17);
		chk_reg(CTL, 8'h02);
		chk({4'h0, scl_oe, sda_oe, irq_bus, irq_data}, 8'h00);
		fm_start();
		chk_reg(SR1, 8'h10);
		fm_stop();
		chk_reg(SR1, 8'h00);
		wr_reg(CTL, 8'h20);
		chk_reg(CTL, 8'h22);
		wr_reg(CTL, 8'h20);
		chk_reg(CTL, 8'h20);
		$display("test disable done");
	endtask : t_disable

	// reset for 16 cycles, then the scenarios in turn
	initial begin
		nrst = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		tb_scl_low = 1'b0;
		tb_sda_low = 1'b0;
		nack = 1'b1;
		failures = 0;
		n_compared = 0;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_enable();
		t_slave();
		t_slave_tx();
		t_master();
		t_nack();
		t_disable();
		stop_test();
	end
endmodule : i2c_ctl_bench
